// ---- verilog/fpd_defines.vh ----
// Constants for the fan PWM duty block: register map, fields, reset values.
// Assumes inclusion by bare name from the design files.
`ifndef FPD_DEFINES_VH
`define FPD_DEFINES_VH

// =====================================================================
// Register map (byte addresses; printed offset 0x05 is an index)
// =====================================================================
`define FPD_IDX_DUTY 8'h05
`define FPD_ADDR_DUTY 8'h14
`define FPD_ADDR_CTRL 8'h20
`define FPD_ADDR_STAT 8'h24
`define FPD_ADDR_AUTO 8'h28

// =====================================================================
// Fields and reset values
// =====================================================================
`define FPD_CODE_HI 7
`define FPD_CODE_LO 4
`define FPD_DUTY_RST 8'hFF
`define FPD_CTRL_RST 8'h00
`define FPD_AUTO_RST 4'h0
`define FPD_CTRL_AUTO 0

// =====================================================================
// Timing
// =====================================================================
`define FPD_PERIOD_STEPS 7'h64
`define FPD_RESP_OKAY 2'h0
`define FPD_RESP_SLVERR 2'h2

`endif

// ---- verilog/fpd_pwm_core.v ----
// PWM core: percent duty in, PWM out, period of 100 prescaled steps.
// Assumes a single clock and synchronous active-low reset.
`timescale 1ns/10ps
`include "fpd_defines.vh"
module fpd_pwm_core #(
   parameter PRESCALE = 16
) (
   input wire aclk,
   input wire aresetn,
   input wire [6:0] duty_pct,
   output reg pwm_q,
   output reg period_start_q
);
   reg [15:0] pre_q;
   reg [6:0] step_q;
   reg [6:0] duty_q;
   wire pre_end;

   assign pre_end = (pre_q == PRESCALE[15:0] - 16'h0001);

   always @(posedge aclk) begin
      if (!aresetn) begin
         pre_q <= 16'h0000;
         step_q <= 7'h00;
         duty_q <= 7'h64;
         pwm_q <= 1'b0;
         period_start_q <= 1'b0;
      end else begin
         pre_q <= pre_end ? 16'h0000 : pre_q + 16'h0001;
         period_start_q <= 1'b0;
         if (pre_end) begin
            if (step_q == `FPD_PERIOD_STEPS - 7'h01) begin
               step_q <= 7'h00;
               duty_q <= duty_pct;
               period_start_q <= 1'b1;
            end else begin
               step_q <= step_q + 7'h01;
            end
         end
         // Duty latched per period so updates never glitch mid-period
         pwm_q <= (step_q < duty_q);
      end
   end
endmodule

// ---- verilog/fpd_top.v ----
// Fan PWM duty control: AXI4-Lite register slave and duty code to PWM.
// Assumes an AXI4-Lite master on aclk and one external fan drive input.
// Functional notes
// (RULE1) After reset the duty register holds 0xFF, giving full duty.
// (RULE2) In manual mode bits 7-4 of the duty register select the duty.
// (RULE3) In auto mode bits 7-4 set the floor under the automatic request.
// (RULE4) Code 0,1,5,6,7,14,15 give 0,7,33,40,47,93,100 percent duty.
// (RULE5) Bits 3-0 of the duty register never affect the output.
// (RULE6) Other codes give code times 100 over 15, rounded to nearest.
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/10ps
`include "fpd_defines.vh"
module fpd_top #(
   parameter PRESCALE = 16
) (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire [3:0] auto_code,
   output reg fan_pwm_q
);
   // ==================================================================
   // Registers
   // ==================================================================
   reg [7:0] duty_reg_q;
   reg [7:0] ctrl_q;
   reg [7:0] aw_q;
   reg aw_have_q;
   reg [31:0] w_q;
   reg [3:0] ws_q;
   reg w_have_q;
   reg [3:0] auto_code_q;
   reg [6:0] applied_pct_q;
   wire pwm_raw;
   wire period_start;
   wire auto_mode;
   wire [3:0] manual_code;
   reg [3:0] eff_code;
   wire [7:0] waddr;
   wire [31:0] wdata;
   wire [3:0] wstrb;
   wire do_write;
   reg [6:0] pct_d;
   wire aw_take;
   wire w_take;
   wire ar_take;
   wire b_done;
   wire r_done;
   wire wr_duty;
   wire wr_ctrl;
   wire wr_stat;
   wire rd_duty;
   wire rd_ctrl;
   wire rd_stat;
   wire rd_auto;
   wire [31:0] stat_word;
   reg [31:0] rdata_d;
   reg [1:0] rresp_d;
   reg [1:0] bresp_d;
   reg [7:0] duty_reg_d;
   reg [7:0] ctrl_d;

   assign auto_mode = ctrl_q[`FPD_CTRL_AUTO];
   // Low nibble is never looked at
   assign manual_code = duty_reg_q[`FPD_CODE_HI:`FPD_CODE_LO]; // [RULE5]

   // ==================================================================
   // Effective duty code
   // ==================================================================
   always @* begin
      eff_code = manual_code; // [RULE2]
      if (auto_mode) begin
         // Auto request is held at or above the programmed floor
         if (auto_code_q < manual_code) begin
            eff_code = manual_code; // [RULE3]
         end else begin
            eff_code = auto_code_q; // [RULE3]
         end
      end
   end

   // ==================================================================
   // Code to percent table
   // ==================================================================
   always @* begin
      case (eff_code)
         4'h0: pct_d = 7'h00;  // [RULE4]
         4'h1: pct_d = 7'h07;  // [RULE4]
         4'h2: pct_d = 7'h0D;  // [RULE6]
         4'h3: pct_d = 7'h14;  // [RULE6]
         4'h4: pct_d = 7'h1B;  // [RULE6]
         4'h5: pct_d = 7'h21;  // [RULE4]
         4'h6: pct_d = 7'h28;  // [RULE4]
         4'h7: pct_d = 7'h2F;  // [RULE4]
         4'h8: pct_d = 7'h35;  // [RULE6]
         4'h9: pct_d = 7'h3C;  // [RULE6]
         4'hA: pct_d = 7'h43;  // [RULE6]
         4'hB: pct_d = 7'h49;  // [RULE6]
         4'hC: pct_d = 7'h50;  // [RULE6]
         4'hD: pct_d = 7'h57;  // [RULE6]
         4'hE: pct_d = 7'h5D;  // [RULE4]
         default: pct_d = 7'h64; // [RULE4]
      endcase
   end

   // ==================================================================
   // Output stage
   // ==================================================================
   always @(posedge aclk) begin
      if (!aresetn) begin
         auto_code_q <= 4'h0;
      end else begin
         auto_code_q <= auto_code;
      end
   end

   // New percent is picked up by the core at its next period start
   always @(posedge aclk) begin
      if (!aresetn) begin
         applied_pct_q <= 7'h64;
         fan_pwm_q <= 1'b0;
      end else begin
         applied_pct_q <= pct_d;
         fan_pwm_q <= pwm_raw;
      end
   end

   fpd_pwm_core #(
      .PRESCALE(PRESCALE)
   ) u_core (
      .aclk(aclk),
      .aresetn(aresetn),
      .duty_pct(applied_pct_q),
      .pwm_q(pwm_raw),
      .period_start_q(period_start)
   );

   // ==================================================================
   // AXI4-Lite write side
   // ==================================================================
   assign aw_take = s_axi_awready && s_axi_awvalid;
   assign w_take = s_axi_wready && s_axi_wvalid;
   assign ar_take = s_axi_arready && s_axi_arvalid;
   assign b_done = s_axi_bvalid && s_axi_bready;
   assign r_done = s_axi_rvalid && s_axi_rready;
   // A half taken earlier stands in for the one not on the bus now
   assign waddr = aw_take ? s_axi_awaddr : aw_q;
   assign wdata = w_take ? s_axi_wdata : w_q;
   assign wstrb = w_take ? s_axi_wstrb : ws_q;
   assign do_write = !s_axi_bvalid && (aw_have_q || aw_take) &&
      (w_have_q || w_take);

   // ==================================================================
   // Address decode (word aligned, low two bits ignored)
   // ==================================================================
   assign wr_duty = ({waddr[7:2], 2'h0} == `FPD_ADDR_DUTY);
   assign wr_ctrl = ({waddr[7:2], 2'h0} == `FPD_ADDR_CTRL);
   assign wr_stat = ({waddr[7:2], 2'h0} == `FPD_ADDR_STAT);
   assign rd_duty = ({s_axi_araddr[7:2], 2'h0} == `FPD_ADDR_DUTY);
   assign rd_ctrl = ({s_axi_araddr[7:2], 2'h0} == `FPD_ADDR_CTRL);
   assign rd_stat = ({s_axi_araddr[7:2], 2'h0} == `FPD_ADDR_STAT);
   assign rd_auto = ({s_axi_araddr[7:2], 2'h0} == `FPD_ADDR_AUTO);

   // ==================================================================
   // Write next values: only byte lane 0 carries register bits
   // ==================================================================
   always @* begin
      duty_reg_d = duty_reg_q;
      ctrl_d = ctrl_q;
      bresp_d = `FPD_RESP_OKAY;
      if (wr_duty) begin
         if (wstrb[0]) begin
            duty_reg_d = wdata[7:0];
         end
      end else if (wr_ctrl) begin
         if (wstrb[0]) begin
            ctrl_d = {7'h00, wdata[0]};
         end
      end else if (!wr_stat) begin
         // Unmapped words and the auto word answer with an error; status word writes answer OKAY
         bresp_d = `FPD_RESP_SLVERR;
      end
   end

   // Address and data halves are held until both are in
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_q <= 8'h00;
         aw_have_q <= 1'b0;
         w_q <= 32'h00000000;
         ws_q <= 4'h0;
         w_have_q <= 1'b0;
      end else if (do_write) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
      end else begin
         if (aw_take) begin
            aw_q <= s_axi_awaddr;
            aw_have_q <= 1'b1;
         end
         if (w_take) begin
            w_q <= s_axi_wdata;
            ws_q <= s_axi_wstrb;
            w_have_q <= 1'b1;
         end
      end
   end

   // Readies pulse one cycle at a time, low while a response waits
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else if (do_write) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_have_q && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready <= !w_have_q && !s_axi_wready && !s_axi_bvalid;
      end
   end

   // Response stands until the master takes it
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `FPD_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= bresp_d;
      end else if (b_done) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Register file
   always @(posedge aclk) begin
      if (!aresetn) begin
         duty_reg_q <= `FPD_DUTY_RST; // [RULE1]
         ctrl_q <= `FPD_CTRL_RST;
      end else if (do_write) begin
         duty_reg_q <= duty_reg_d;
         ctrl_q <= ctrl_d;
      end
   end

   // ==================================================================
   // AXI4-Lite read side
   // ==================================================================
   // Status word: period start, output level, code, applied percent
   assign stat_word = {18'h00000, period_start, fan_pwm_q, eff_code,
      1'b0, applied_pct_q};

   // Unmapped words read as zero with an error
   always @* begin
      rdata_d = 32'h00000000;
      rresp_d = `FPD_RESP_OKAY;
      if (rd_duty) begin
         rdata_d = {24'h000000, duty_reg_q};
      end else if (rd_ctrl) begin
         rdata_d = {24'h000000, ctrl_q};
      end else if (rd_stat) begin
         rdata_d = stat_word;
      end else if (rd_auto) begin
         rdata_d = {28'h0000000, auto_code_q};
      end else begin
         rresp_d = `FPD_RESP_SLVERR;
      end
   end

   // Read ready pulses while idle; one read answered at a time
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
      end else if (ar_take) begin
         s_axi_arready <= 1'b0;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `FPD_RESP_OKAY;
      end else if (ar_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= rresp_d;
         s_axi_rdata <= rdata_d;
      end else if (r_done) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// ---- verification/fpd_chk_sva.sv ----
// Checker bound into fpd_top: bus answers, reset level, PWM period.
// Assumes PRESCALE equal to that of the bound instance.
`timescale 1ns/10ps
module fpd_chk #(
   parameter PRESCALE = 16
) (
   input wire aclk,
   input wire aresetn,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire fan_pwm_q
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic last_q = 1'h0, seen_q = 1'h0;
   int gap_q = 0;
   wire rise = fan_pwm_q && !last_q;
   // Cycles since the last rising edge of the fan output
   always @(posedge aclk) begin
      last_q <= fan_pwm_q;
      gap_q <= rise ? 1 : gap_q + 1;
      seen_q <= aresetn && (seen_q || rise);
   end
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid) else $error("bvalid dropped");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("no read answer");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
   err_data_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |->
      s_axi_rdata == 32'h0) else $error("error read data");
   rst_low_a: assert property ($rose(aresetn) |-> !fan_pwm_q)
      else $error("fan on after reset");
   pwm_period_a: assert property (rise && seen_q |->
      gap_q % (100 * PRESCALE) == 0) else $error("bad PWM period");
   cover property (s_axi_bvalid && !s_axi_bready);
   cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
   cover property (rise && seen_q);
endmodule
bind fpd_top fpd_chk #(.PRESCALE(PRESCALE)) chk_u (.aclk, .aresetn,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .fan_pwm_q);

// ---- verification/fpd_fan_model.sv ----
// Fan drive model: drive level is the high count of the last 100 cycles.
// Assumes PRESCALE 1, so the window is one whole PWM period.
`timescale 1ns/10ps
module fpd_fan_model (
   input wire aclk,
   input wire fan_pwm_q,
   output wire [6:0] drive_pct
);
   logic [99:0] win_q = 100'h0;
   always @(posedge aclk) win_q <= {win_q[98:0], fan_pwm_q};
   assign drive_pct = 7'($countones(win_q));
endmodule

// ---- verification/tb_top.sv ----
// Bench for fpd_top: registers, duty codes, auto floor, bad address.
// Assumes PRESCALE 1: one PWM period is 100 clock cycles.
`timescale 1ns/10ps
`include "fpd_defines.vh"
module tb_top;
   logic aclk = 1'h0, aresetn = 1'h0, smp = 1'h0, awvalid = 1'h0;
   logic wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [7:0] awaddr = 8'h0, araddr = 8'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] auto_code = 4'h0;
   logic [33:0] q[$];
   logic [33:0] got, e;
   wire awready, wready, bvalid, arready, rvalid, pwm;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [6:0] pct;
   int error_cnt = 0, checks = 0, cyc = 0;
   always #5 aclk = ~aclk;
   fpd_top #(.PRESCALE(1)) dut_u (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .auto_code(auto_code), .fan_pwm_q(pwm));
   fpd_fan_model fan_u (.aclk(aclk), .fan_pwm_q(pwm), .drive_pct(pct));
   task automatic close_out();
      if (error_cnt == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Result watcher and hang limit
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (smp || bvalid && bready || rvalid && rready) begin
         got = rvalid ? {rresp, rdata} : {bresp, 32'h0};
         got = smp ? {27'h0, pct} : got;
         e = q.pop_front();
         checks++;
         if (got !== e) begin
            error_cnt++;
            $display("mismatch at %0t: got %h exp %h", $time, got, e);
         end
      end
      if (cyc == 20000) begin
         error_cnt++;
         close_out();
      end
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
         input logic [1:0] r);
      q.push_back({r, 32'h0});
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      do begin
         @(posedge aclk);
         awvalid <= awvalid && !awready;
         wvalid <= wvalid && !wready;
      end while (awvalid && !awready || wvalid && !wready);
      repeat ($urandom % 3) @(posedge aclk);
      bready <= 1'h1;
      do @(posedge aclk); while (!bvalid);
      bready <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [33:0] x);
      q.push_back(x);
      araddr <= a;
      arvalid <= 1'h1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'h0;
      repeat ($urandom % 3) @(posedge aclk);
      rready <= 1'h1;
      do @(posedge aclk); while (!rvalid);
      rready <= 1'h0;
   endtask
   // Waits out 250 cycles (two and a half periods), then compares the fan drive level
   task automatic duty(input int p);
      repeat (250) @(posedge aclk);
      q.push_back({27'h0, 7'(p)});
      smp <= 1'h1;
      @(posedge aclk);
      smp <= 1'h0;
   endtask
   initial begin
      void'($urandom(14));
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      rd(`FPD_ADDR_DUTY, 34'hFF);
      duty(100);
      for (int c = 0; c < 16; c++) begin
         wr(`FPD_ADDR_DUTY, {24'h0, c[3:0], 4'($urandom)}, 2'h0);
         duty((c * 100 + 7) / 15);
      end
      wr(`FPD_ADDR_CTRL, 32'h1, 2'h0);
      for (int a = 0; a < 16; a += 5) begin
         auto_code <= 4'(a);
         wr(`FPD_ADDR_DUTY, {24'h5, 4'($urandom)}, 2'h0);
         duty(((a > 5 ? a : 5) * 100 + 7) / 15);
      end
      rd(`FPD_ADDR_CTRL, 34'h1);
      rd(`FPD_ADDR_AUTO, 34'hF);
      wr(8'h30, 32'h0, 2'h2);
      rd(8'h30, {2'h2, 32'h0});
      close_out();
   end
endmodule
